// ---- core/dpm_pkg.sv ----
// Purpose: shared constants and types for the debug/program port mode select
// Assumes: one system clock plus one link clock from the emulator
// Notes:   mode encodings are internal to the block
package dpm_pkg;

  typedef enum logic [1:0]
  {
    DPM_IF_ONE_PIN,
    DPM_IF_FOUR_PIN,
    DPM_IF_JTAG
  } dpm_iface_type;

  typedef enum logic [1:0]
  {
    DPM_PROG_UART1,
    DPM_PROG_UART2,
    DPM_PROG_CLKSER
  } dpm_prog_type;

  typedef enum logic [1:0]
  {
    DPM_MODE_NORMAL,
    DPM_MODE_USER_BOOT,
    DPM_MODE_SERIAL_PROG
  } dpm_mode_type;

  // option bit value for the one-pin and four-pin link choices, and after reset
  localparam logic DPM_OPT_ONE_PIN  = 1'b0;
  localparam logic DPM_OPT_FOUR_PIN = 1'b1;
  localparam logic DPM_OPT_RESET    = 1'b0;

  // pin levels that request serial programming
  localparam logic DPM_PROG_PIN_A_LVL = 1'b1;
  localparam logic DPM_PROG_PIN_B_LVL = 1'b0;

  typedef struct packed
  {
    logic data_out;
    logic clock_out;
    logic ready_n;
  } dpm_link_out_type;

  typedef struct packed
  {
    logic reset_n;
    logic data_in;
    logic tms;
  } dpm_link_in_type;

endpackage

// ---- core/dpm_port.sv ----
// Purpose: device side mode and interface selection for debug/programming
// Assumes: clk_i 25 MHz; link clock from the emulator, free running in a
//          session; option bit write port fed by the flash programming path
// Notes:   the link logic itself is a loopback shell; protocol engines sit
//          outside and use the selected-mode outputs
//
// Behaviour
// - mode and link follow use, serial programming or a debug link.
// - serial programming entry is accepted even during a debug session.
// - debugger downloads to flash go through self programming.
// - debug runs in normal or user boot mode on one-pin, four-pin or JTAG.
// - one nonvolatile option bit picks the offered one-pin or four-pin link; JTAG is always offered.
// - no one-pin or four-pin session starts when option and debugger choice differ.
// - a mismatched option bit is rewritten, then normal mode, then debug.
// - events are driven on a dedicated event output when present, in a four-pin or JTAG session.
// - a shared event pin shows events only once software selects it.
// - link reset and ready are active low, outputs device side.
`timescale 1ns/100ps
module dpm_port
  import dpm_pkg::*;
#(
  parameter int EVENT_W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         debug_link_clock_in_i,
  input  wire logic         prog_mode_pin_a_i,
  input  wire logic         prog_mode_pin_b_i,
  input  wire logic         boot_user_i,
  input  wire logic         debugger_active_i,
  input  wire dpm_iface_type debugger_iface_i,
  input  wire dpm_prog_type prog_iface_i,
  input  wire logic         option_nv_i,
  input  wire logic         option_wr_i,
  input  wire logic         option_wr_val_i,
  input  wire logic         flash_dl_req_i,
  input  wire logic         event_pin_present_i,
  input  wire logic         event_pin_shared_i,
  input  wire logic         event_pin_sel_i,
  input  wire logic [EVENT_W-1:0] event_i,
  input  wire dpm_link_in_type link_in_i,
  input  wire logic         debug_link_data_bidir_i,
  input  wire logic         link_tx_i,
  input  wire logic         link_tx_en_i,
  output dpm_mode_type      mode_o,
  output logic              debug_session_o,
  output logic              iface_mismatch_o,
  output logic              option_bit_o,
  output logic              self_prog_o,
  output logic              serial_prog_o,
  output logic              event_output_o,
  output dpm_link_out_type  link_out_o,
  output logic              debug_link_data_bidir_o,
  output logic              debug_link_data_bidir_oe_n_o,
  output logic              link_rx_o
);

  typedef enum
  {
    ST_IDLE,
    ST_PROG,
    ST_DEBUG
  } dpm_state_type;

  dpm_state_type state;
  logic          pa_s1, pa_s2, pb_s1, pb_s2, da_s1, da_s2;
  logic          sess_s1, sess_s2;
  logic          ready_link;
  logic          prog_req;
  logic          dbg_ok;
  logic          ev_en;
  logic          rx_l;
  logic          rx_s1, sess_src;
  logic          lrst_s1, lrst_s2, lrn_s1, lrn_s2;
  logic          rdy_s1, rdy_s2;

  // mode pins and debugger request come from outside this clock
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pa_s1 <= 1'b0;
      pa_s2 <= 1'b0;
      pb_s1 <= 1'b1;
      pb_s2 <= 1'b1;
      da_s1 <= 1'b0;
      da_s2 <= 1'b0;
    end
    else
    begin
      pa_s1 <= prog_mode_pin_a_i;
      pa_s2 <= pa_s1;
      pb_s1 <= prog_mode_pin_b_i;
      pb_s2 <= pb_s1;
      da_s1 <= debugger_active_i;
      da_s2 <= da_s1;
    end
  end

  // pin levels
  // request for serial programming
  assign prog_req = (pa_s2 == DPM_PROG_PIN_A_LVL)
                 && (pb_s2 == DPM_PROG_PIN_B_LVL);

  // option selects link
  // only one-pin and four-pin are keyed by the bit; jtag always allowed
  always_comb
  begin
    case (debugger_iface_i)
      DPM_IF_ONE_PIN:  dbg_ok = (option_bit_o == DPM_OPT_ONE_PIN);
      DPM_IF_FOUR_PIN: dbg_ok = (option_bit_o == DPM_OPT_FOUR_PIN);
      default:         dbg_ok = 1'b1;
    endcase
  end

  // option rewrite
  // bit rewritten only in serial programming, as the emulator does it
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      option_bit_o <= DPM_OPT_RESET;
    else if (state == ST_IDLE)
      option_bit_o <= option_nv_i;
    else if (option_wr_i && state == ST_PROG)
      option_bit_o <= option_wr_val_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          if (prog_req)
            state <= ST_PROG;
          else if (da_s2 && dbg_ok)
            state <= ST_DEBUG;
        ST_PROG:
          if (!prog_req)
            state <= ST_IDLE;
        ST_DEBUG:
          if (prog_req)
            state <= ST_PROG;
          else if (!da_s2)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  always_comb
  begin
    case (state)
      ST_PROG: mode_o = DPM_MODE_SERIAL_PROG;
      default: mode_o = boot_user_i ? DPM_MODE_USER_BOOT : DPM_MODE_NORMAL;
    endcase
  end

  assign serial_prog_o    = (state == ST_PROG);
  assign debug_session_o  = (state == ST_DEBUG);
  assign iface_mismatch_o = da_s2 && !dbg_ok;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      self_prog_o <= 1'b0;
    else
      self_prog_o <= flash_dl_req_i && (state == ST_DEBUG);
  end

  assign ev_en = event_pin_present_i
              && debug_session_o
              && (debugger_iface_i != DPM_IF_ONE_PIN)
              && (!event_pin_shared_i || event_pin_sel_i);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      event_output_o <= 1'b0;
    else
      event_output_o <= ev_en && (|event_i);
  end

  // session flag from a flop, so no decode glitch crosses over
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sess_src <= 1'b0;
    else
      sess_src <= (state == ST_DEBUG);
  end

  // system reset and link reset pin into the link domain
  always_ff @(posedge debug_link_clock_in_i)
  begin
    lrst_s1 <= reset_i;
    lrst_s2 <= lrst_s1;
    lrn_s1  <= link_in_i.reset_n;
    lrn_s2  <= lrn_s1;
  end

  // session level crosses into the link domain
  always_ff @(posedge debug_link_clock_in_i)
  begin
    if (lrst_s2)
    begin
      sess_s1 <= 1'b0;
      sess_s2 <= 1'b0;
    end
    else
    begin
      sess_s1 <= sess_src;
      sess_s2 <= sess_s1;
    end
  end

  always_ff @(posedge debug_link_clock_in_i)
  begin
    if (lrst_s2 || !lrn_s2)
      ready_link <= 1'b0;
    else
      ready_link <= sess_s2;
  end

  // link ready back into the system domain
  always_ff @(posedge clk_i)
  begin
    rdy_s1 <= ready_link;
    rdy_s2 <= rdy_s1;
  end

  // one-pin turnaround
  // protocol owns direction; oe low drives the line
  assign debug_link_data_bidir_o      = link_tx_i;
  assign debug_link_data_bidir_oe_n_o =
    !(debug_session_o && link_tx_en_i
      && debugger_iface_i == DPM_IF_ONE_PIN);

  // received line comes straight from a pin: two flops
  always_ff @(posedge clk_i)
    rx_s1 <= (debugger_iface_i == DPM_IF_ONE_PIN || serial_prog_o)
             ? debug_link_data_bidir_i : link_in_i.data_in;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rx_l <= 1'b0;
    else
      rx_l <= rx_s1;
  end
  assign link_rx_o = rx_l;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      link_out_o <= '{data_out: 1'b0, clock_out: 1'b0, ready_n: 1'b1};
    else
    begin
      link_out_o.data_out  <= link_tx_i;
      link_out_o.clock_out <= debug_session_o
                              && debugger_iface_i == DPM_IF_FOUR_PIN
                              && prog_iface_i != DPM_PROG_CLKSER;
      link_out_o.ready_n   <= !(debug_session_o && rdy_s2
                              && debugger_iface_i == DPM_IF_JTAG);
    end
  end

  // assertion helpers
  logic ready_seen;
  assign ready_seen = ready_link;

  mode_prog_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state == ST_IDLE && prog_req) |=> serial_prog_o)
    else $error("programming request not taken");
  prog_in_dbg_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state == ST_DEBUG && prog_req) |=> state == ST_PROG)
    else $error("programming locked out during debug");
  self_prog_a: assert property (@(posedge clk_i) disable iff (reset_i)
    self_prog_o |-> $past(state) == ST_DEBUG)
    else $error("self programming outside debug");
  dbg_mode_a: assert property (@(posedge clk_i) disable iff (reset_i)
    debug_session_o |-> mode_o != DPM_MODE_SERIAL_PROG)
    else $error("debug in serial programming mode");
  no_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state == ST_IDLE && !dbg_ok) |=> state != ST_DEBUG)
    else $error("debug started on mismatch");
  opt_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (option_wr_i && state == ST_PROG)
      |=> option_bit_o == $past(option_wr_val_i))
    else $error("option rewrite lost");
  event_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (event_pin_shared_i && !event_pin_sel_i) |=> !event_output_o)
    else $error("event on unselected pin");
  bidir_drive_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !debug_session_o |-> debug_link_data_bidir_oe_n_o)
    else $error("data line driven outside debug");
  ready_low_a: assert property (@(posedge debug_link_clock_in_i)
    disable iff (reset_i)
    !lrn_s2 |=> !ready_seen)
    else $error("link ready while link reset");

  cov_prog: cover property (@(posedge clk_i) disable iff (reset_i)
    state == ST_PROG);
  cov_debug: cover property (@(posedge clk_i) disable iff (reset_i)
    state == ST_DEBUG ##1 state == ST_PROG);
  cov_event: cover property (@(posedge clk_i) disable iff (reset_i)
    event_output_o);

endmodule

// ---- tb/dpm_emu.sv ----
// Purpose: emulator model on the far side of the debug/program port
// Assumes: bench requests change at clk_i edges
// Notes:   lines unused by the chosen mode are released, read pulled high
`timescale 1ns/100ps
module dpm_emu
  import dpm_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          prog_req_i,
  input  wire logic          dbg_req_i,
  input  wire dpm_iface_type iface_i,
  input  wire logic          dev_oe_n_i,
  input  wire logic          dev_data_i,
  output logic               pin_a_o,
  output logic               pin_b_o,
  output logic               dbg_active_o,
  output dpm_iface_type      iface_o,
  output dpm_link_in_type    link_o,
  output logic               line_o
);
  logic toggle = 1'b0;
  logic line_used;
  assign line_used = (dbg_req_i && iface_i == DPM_IF_ONE_PIN) || prog_req_i;
  always @(posedge clk_i)
  begin
    toggle <= ~toggle;
    pin_a_o <= prog_req_i ? DPM_PROG_PIN_A_LVL : 1'b0;
    pin_b_o <= prog_req_i ? DPM_PROG_PIN_B_LVL : 1'b1;
    dbg_active_o <= dbg_req_i;
    iface_o <= iface_i;
    // link reset low until the debugger is up
    link_o.reset_n <= dbg_req_i;
    // a line the mode does not use is left released
    link_o.tms <= (dbg_req_i && iface_i == DPM_IF_JTAG) ? toggle : 1'b1;
    link_o.data_in <= (dbg_req_i && iface_i != DPM_IF_ONE_PIN)
                      ? ~toggle : 1'b1;
  end
  // device wins the shared line while it drives
  assign line_o = !dev_oe_n_i ? dev_data_i : (line_used ? toggle : 1'b1);
endmodule

// ---- tb/debug_program_port_mode_select_bench.sv ----
// Purpose: directed bench for dpm_port
// Assumes: bench drives inputs by nonblocking assignment at clk_i
// Notes:   state settles 3 edges after pins, plus one for the model
`timescale 1ns/100ps
module debug_program_port_mode_select_bench;
  import dpm_pkg::*;
  logic clk_i = 0, lclk = 0, reset_i = 1, prog_req = 0, dbg_req = 0;
  dpm_iface_type req_if = DPM_IF_FOUR_PIN, debugger_iface_i;
  logic prog_mode_pin_a_i, prog_mode_pin_b_i, debugger_active_i;
  logic boot_user_i = 0, option_nv_i = 0, option_wr_i = 0;
  logic option_wr_val_i = 0, flash_dl_req_i = 0, event_pin_present_i = 0;
  logic event_pin_shared_i = 0, event_pin_sel_i = 0;
  logic [0:0] event_i = 0;
  logic link_tx_i = 0, link_tx_en_i = 0, line;
  dpm_link_in_type link_in_i;
  dpm_mode_type mode_o;
  dpm_link_out_type link_out_o;
  logic debug_session_o, iface_mismatch_o, option_bit_o, self_prog_o;
  logic serial_prog_o, event_output_o, bidir_o, oe_n, link_rx_o;
  int n_errors = 0, checks_done = 0;
  always #20 clk_i = ~clk_i;
  always #32 lclk = ~lclk;
  dpm_port #(.EVENT_W(1)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .debug_link_clock_in_i(lclk),
    .prog_mode_pin_a_i(prog_mode_pin_a_i),
    .prog_mode_pin_b_i(prog_mode_pin_b_i), .boot_user_i(boot_user_i),
    .debugger_active_i(debugger_active_i),
    .debugger_iface_i(debugger_iface_i), .prog_iface_i(DPM_PROG_UART2),
    .option_nv_i(option_nv_i), .option_wr_i(option_wr_i),
    .option_wr_val_i(option_wr_val_i), .flash_dl_req_i(flash_dl_req_i),
    .event_pin_present_i(event_pin_present_i),
    .event_pin_shared_i(event_pin_shared_i),
    .event_pin_sel_i(event_pin_sel_i), .event_i(event_i),
    .link_in_i(link_in_i), .debug_link_data_bidir_i(line),
    .link_tx_i(link_tx_i), .link_tx_en_i(link_tx_en_i), .mode_o(mode_o),
    .debug_session_o(debug_session_o), .iface_mismatch_o(iface_mismatch_o),
    .option_bit_o(option_bit_o), .self_prog_o(self_prog_o),
    .serial_prog_o(serial_prog_o), .event_output_o(event_output_o),
    .link_out_o(link_out_o), .debug_link_data_bidir_o(bidir_o),
    .debug_link_data_bidir_oe_n_o(oe_n), .link_rx_o(link_rx_o));
  dpm_emu emu (
    .clk_i(clk_i), .prog_req_i(prog_req), .dbg_req_i(dbg_req),
    .iface_i(req_if), .dev_oe_n_i(oe_n), .dev_data_i(bidir_o),
    .pin_a_o(prog_mode_pin_a_i), .pin_b_o(prog_mode_pin_b_i),
    .dbg_active_o(debugger_active_i), .iface_o(debugger_iface_i),
    .link_o(link_in_i), .line_o(line));
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_mode(input dpm_mode_type exp);
    checks_done++;
    if (mode_o !== exp)
    begin
      n_errors++;
      $display("mismatch mode_o expected %0d seen %0d", exp, mode_o);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    step(2000);
    n_errors++;
    conclude();
  end
  initial
  begin
    step(10);
    reset_i <= 0;
    dbg_req <= 1;
    step(5);
    chk("iface_mismatch_o", 1, iface_mismatch_o);
    chk("debug_session_o", 0, debug_session_o);
    prog_req <= 1;
    step(5);
    chk("serial_prog_o", 1, serial_prog_o);
    chk_mode(DPM_MODE_SERIAL_PROG);
    option_wr_i <= 1;
    option_wr_val_i <= DPM_OPT_FOUR_PIN;
    step(1);
    option_wr_i <= 0;
    step(1);
    chk("option_bit_o", 1, option_bit_o);
    option_nv_i <= 1;
    prog_req <= 0;
    step(6);
    chk("debug_session_o", 1, debug_session_o);
    chk("iface_mismatch_o", 0, iface_mismatch_o);
    chk_mode(DPM_MODE_NORMAL);
    option_wr_i <= 1;
    option_wr_val_i <= 0;
    step(1);
    option_wr_i <= 0;
    step(1);
    chk("option_bit_o", 1, option_bit_o);
    event_pin_present_i <= 1;
    event_pin_shared_i <= 1;
    event_i <= 1;
    step(2);
    chk("event_output_o", 0, event_output_o);
    event_pin_sel_i <= 1;
    step(2);
    chk("event_output_o", 1, event_output_o);
    chk("clock_out", 1, link_out_o.clock_out);
    flash_dl_req_i <= 1;
    boot_user_i <= 1;
    step(2);
    chk("self_prog_o", 1, self_prog_o);
    chk("serial_prog_o", 0, serial_prog_o);
    chk_mode(DPM_MODE_USER_BOOT);
    flash_dl_req_i <= 0;
    prog_req <= 1;
    step(5);
    chk("serial_prog_o", 1, serial_prog_o);
    prog_req <= 0;
    req_if <= DPM_IF_JTAG;
    step(16);
    chk("debug_session_o", 1, debug_session_o);
    chk("ready_n", 0, link_out_o.ready_n);
    dbg_req <= 0;
    option_nv_i <= 0;
    step(5);
    req_if <= DPM_IF_ONE_PIN;
    dbg_req <= 1;
    link_tx_en_i <= 1;
    link_tx_i <= 1;
    step(5);
    chk("oe_n", 0, oe_n);
    chk("bidir_o", 1, bidir_o);
    chk("event_output_o", 0, event_output_o);
    step(2);
    chk("link_rx_o", 1, link_rx_o);
    chk("data_out", 1, link_out_o.data_out);
    conclude();
  end
endmodule
